// file: inc/cio_pkg.sv
/*
 * Shared constants for the configurable pin block with its status
 * indicator: pin count, pin modes, device status codes and blink timing.
 * Assumes a 25 MHz system clock.
 */
`default_nettype none
package cio_pkg;
    // ************************************************************
    // Pin set and command encoding.
    // ************************************************************
    localparam int NUM_PINS = 10;
    localparam int PIN_W = 4;
    // Pin numbers in commands start at one.
    localparam logic [3:0] PIN_FIRST = 4'h1;
    // Only the first pin carries the status indicator.
    localparam logic [3:0] ALT_PIN = 4'h1;
    localparam logic [1:0] MODE_IN = 2'h0;
    localparam logic [1:0] MODE_OUT = 2'h1;
    localparam logic [1:0] MODE_ALT = 2'h2;
    localparam logic [1:0] MODE_RESET = MODE_IN;
    localparam logic VAL_RESET = 1'h0;

    // ************************************************************
    // Device status as seen by the indicator.
    // ************************************************************
    typedef enum logic [2:0] {
        CIO_DEV_OFF = 3'h0,
        CIO_DEV_NOT_REG = 3'h1,
        CIO_DEV_IDLE = 3'h2,
        CIO_DEV_IDLE_PSM = 3'h3,
        CIO_DEV_CONNECTING = 3'h4
    } cio_dev_e;

    // ************************************************************
    // Blink timing.
    // ************************************************************
    localparam longint CLK_HZ = 25000000;
    localparam longint LED_ON_MS = 1000;
    localparam longint LED_OFF_MS = 2000;
    localparam int unsigned LED_ON_CYC =
        32'(LED_ON_MS * CLK_HZ / 1000);
    localparam int unsigned LED_OFF_CYC =
        32'(LED_OFF_MS * CLK_HZ / 1000);
endpackage
`default_nettype wire

// file: logic/cio_gpio.sv
/*
 * Ten configurable pins with input, output and alternate function
 * modes; the first pin's alternate function is the network status
 * indicator. Assumes pad inputs are asynchronous, while commands,
 * reads, device status and wake events come from logic on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module cio_gpio #(
    parameter int NUM_PINS = cio_pkg::NUM_PINS,
    parameter int unsigned ON_CYCLES = cio_pkg::LED_ON_CYC,
    parameter int unsigned OFF_CYCLES = cio_pkg::LED_OFF_CYC
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Pin configuration command.
    input wire logic cmd_valid,
    input wire logic [cio_pkg::PIN_W-1:0] cmd_pin,
    input wire logic [1:0] cmd_mode,
    input wire logic cmd_value,
    output logic cmd_err,
    // Pin read request and answer.
    input wire logic rd_req,
    input wire logic [cio_pkg::PIN_W-1:0] rd_pin,
    output logic rd_data,
    output logic rd_done,
    // Device status from firmware.
    input wire cio_pkg::cio_dev_e dev_state,
    input wire logic wake_evt,
    // Pads.
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe,
    output logic [NUM_PINS-1:0] pad_pd
);
    // ************************************************************
    // Elaboration checks.
    // ************************************************************
    if (NUM_PINS < 1 || NUM_PINS > 15) begin : g_bad_pins
        $error("NUM_PINS must be 1 to 15");
    end
    if (ON_CYCLES < 1 || OFF_CYCLES < 1) begin : g_bad_time
        $error("Blink phases need at least one cycle");
    end

    localparam int unsigned PERIOD = ON_CYCLES + OFF_CYCLES;

    // ************************************************************
    // State declarations.
    // ************************************************************
    logic [1:0] mode_r [NUM_PINS];
    logic [1:0] mode_nxt [NUM_PINS];
    logic [NUM_PINS-1:0] val_r, val_nxt;
    logic [NUM_PINS-1:0] sync1_r, sync2_r;
    logic [NUM_PINS-1:0] out_r, out_nxt, oe_r, oe_nxt, pd_r, pd_nxt;
    logic err_r, err_nxt, rdd_r, rdd_nxt, rdv_r, rdv_nxt;
    logic led_r, led_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic blink, cmd_ok;
    logic [cio_pkg::PIN_W-1:0] cidx, ridx;

    // Two flip-flops bring each pad level into the clock domain.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
        end
    end

    // ************************************************************
    // Pin configuration and read-back.
    // ************************************************************
    // Decodes commands and reads; only the addressed pin changes.
    always_comb begin
        cidx = cmd_pin - cio_pkg::PIN_FIRST;
        ridx = rd_pin - cio_pkg::PIN_FIRST;
        cmd_ok = (cmd_pin >= cio_pkg::PIN_FIRST)
            && (cidx < NUM_PINS[cio_pkg::PIN_W-1:0])
            && (cmd_mode <= cio_pkg::MODE_ALT)
            && (cmd_mode != cio_pkg::MODE_ALT
                || cmd_pin == cio_pkg::ALT_PIN);
        for (int i = 0; i < NUM_PINS; i++) begin
            mode_nxt[i] = mode_r[i];
        end
        val_nxt = val_r;
        err_nxt = cmd_valid && !cmd_ok;
        if (cmd_valid && cmd_ok) begin
            mode_nxt[cidx] = cmd_mode;
            val_nxt[cidx] = cmd_value;
        end
        rdv_nxt = rd_req;
        rdd_nxt = 1'b0;
        if (rd_req && rd_pin >= cio_pkg::PIN_FIRST
                && ridx < NUM_PINS[cio_pkg::PIN_W-1:0]) begin
            if (mode_r[ridx] == cio_pkg::MODE_OUT) begin
                rdd_nxt = val_r[ridx];
            end else begin
                rdd_nxt = sync2_r[ridx];
            end
        end
    end

    // Registers pin settings; reset leaves every pin an input.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                mode_r[i] <= cio_pkg::MODE_RESET;
            end
            val_r <= {NUM_PINS{cio_pkg::VAL_RESET}};
            err_r <= 1'b0;
            rdd_r <= 1'b0;
            rdv_r <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                mode_r[i] <= mode_nxt[i];
            end
            val_r <= val_nxt;
            err_r <= err_nxt;
            rdd_r <= rdd_nxt;
            rdv_r <= rdv_nxt;
        end
    end

    // ************************************************************
    // Status indicator.
    // ************************************************************
    // Blink counter and indicator level from the device status.
    always_comb begin
        blink = (dev_state == cio_pkg::CIO_DEV_IDLE)
            || (dev_state == cio_pkg::CIO_DEV_CONNECTING);
        cnt_nxt = '0;
        led_nxt = led_r;
        if (blink) begin
            cnt_nxt = (cnt_r >= PERIOD - 1) ? '0 : cnt_r + 32'h1;
        end
        unique case (dev_state)
            cio_pkg::CIO_DEV_OFF: led_nxt = 1'b0;
            cio_pkg::CIO_DEV_NOT_REG: led_nxt = 1'b1;
            cio_pkg::CIO_DEV_IDLE,
            cio_pkg::CIO_DEV_CONNECTING: begin
                led_nxt = cnt_r < ON_CYCLES;
            end
            cio_pkg::CIO_DEV_IDLE_PSM: begin
                led_nxt = wake_evt ? !led_r : led_r;
            end
            default: led_nxt = 1'b0;
        endcase
    end

    // Registers the indicator state.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            led_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            led_r <= led_nxt;
        end
    end

    // ************************************************************
    // Pad drivers.
    // ************************************************************
    // Output pins drive push-pull; alternate pin follows the indicator.
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            oe_nxt[i] = mode_r[i] != cio_pkg::MODE_IN;
            pd_nxt[i] = mode_r[i] == cio_pkg::MODE_IN;
            out_nxt[i] = (mode_r[i] == cio_pkg::MODE_OUT) && val_r[i];
        end
        if (mode_r[0] == cio_pkg::MODE_ALT) begin
            out_nxt[0] = led_r;
        end
    end

    // Registers the pad drive.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_r <= '0;
            oe_r <= '0;
            pd_r <= '1;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pd_r <= pd_nxt;
        end
    end

    assign pad_out = out_r;
    assign pad_oe = oe_r;
    assign pad_pd = pd_r;
    assign cmd_err = err_r;
    assign rd_data = rdd_r;
    assign rd_done = rdv_r;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_in_read: assert property (rd_req && rd_pin == 4'h2 && mode_r[1]
        == cio_pkg::MODE_IN |=> rd_data == $past(sync2_r[1]) && rd_done)
        else $error("Input read wrong");
    a_out_read: assert property (rd_req && rd_pin == 4'h4 && mode_r[3]
        == cio_pkg::MODE_OUT |=> rd_data == $past(val_r[3]) && rd_done)
        else $error("Output read wrong");
    a_alt_drive: assert property (mode_r[0] == cio_pkg::MODE_ALT
        |=> pad_out[0] == $past(led_r) && pad_oe[0])
        else $error("Alternate pin not driven by indicator");
    a_out_push: assert property (mode_r[3] == cio_pkg::MODE_OUT
        |=> pad_oe[3] && !pad_pd[3] && pad_out[3] == $past(val_r[3]))
        else $error("Output pin not driven");
    a_alt_only1: assert property (cmd_valid && cmd_pin == 4'h2
        && cmd_mode == cio_pkg::MODE_ALT |=> cmd_err
        && mode_r[1] != cio_pkg::MODE_ALT)
        else $error("Alternate accepted off pin one");
    a_led_static: assert property (dev_state == cio_pkg::CIO_DEV_OFF
        || dev_state == cio_pkg::CIO_DEV_NOT_REG
        |=> led_r == ($past(dev_state) == cio_pkg::CIO_DEV_NOT_REG))
        else $error("Static indicator level wrong");
    a_blink_phase: assert property (blink |=> led_r
        == ($past(cnt_r) < ON_CYCLES))
        else $error("Blink phase wrong");
    a_blink_wrap: assert property (blink && cnt_r == PERIOD - 1
        |=> cnt_r == 0)
        else $error("Blink period wrong");
    a_psm_hold: assert property (dev_state == cio_pkg::CIO_DEV_IDLE_PSM
        && !wake_evt |=> $stable(led_r))
        else $error("Indicator moved without wake");
    a_in_default: assert property (mode_r[2] == cio_pkg::MODE_IN
        |=> pad_pd[2] && !pad_oe[2])
        else $error("Input pin without pull-down");
    a_pin_indep: assert property (cmd_valid && cmd_pin != 4'h1
        |=> $stable(mode_r[0]) && $stable(val_r[0]))
        else $error("Other pin disturbed");
endmodule
`default_nettype wire

// file: tb/cio_pad_model.sv
/*
 * Far-side model: external drivers on the ten pads.
 * Assumes the pad control signals of the pin block, one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module cio_pad_model (
    // Pin block side.
    input wire logic [9:0] pad_out,
    input wire logic [9:0] pad_oe,
    input wire logic [9:0] pad_pd,
    // Test stimulus side.
    input wire logic [9:0] ext_en,
    input wire logic [9:0] ext_drv,
    output logic [9:0] pad_in
);
    // The block wins when it drives; a released pad falls to the pull-down.
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_en[i])
                pad_in[i] = ext_drv[i];
            else
                pad_in[i] = pad_pd[i] ? 1'b0 : 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: tb/config_io_with_status_led_tb_top.sv
/*
 * Self-checking bench for the pin block and its status indicator.
 * Assumes the pad model beside it and short blink counts of 4 and 8.
 */
`timescale 1ns/10ps
`default_nettype none
module config_io_with_status_led_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0, cmd_value = 1'b0, rd_req = 1'b0;
    logic wake_evt = 1'b0, cmd_err, rd_data, rd_done, v;
    logic [3:0] cmd_pin = 4'h0, rd_pin = 4'h0;
    logic [1:0] cmd_mode = 2'h0;
    cio_pkg::cio_dev_e dev_state = cio_pkg::CIO_DEV_OFF;
    logic [9:0] pad_in, pad_out, pad_oe, pad_pd, ext_drv = 10'h000;
    logic [9:0] ext_en = 10'h3FF;
    logic rd_q[$];
    int err_total = 0, n_compared = 0, err_seen = 0, err_exp = 0, n;
    int seed = 32'h375006bb;

    always #20 clk_sys = ~clk_sys;

    cio_gpio #(.NUM_PINS(10), .ON_CYCLES(4), .OFF_CYCLES(8)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_pin(cmd_pin), .cmd_mode(cmd_mode), .cmd_value(cmd_value),
        .cmd_err(cmd_err), .rd_req(rd_req), .rd_pin(rd_pin),
        .rd_data(rd_data), .rd_done(rd_done), .dev_state(dev_state),
        .wake_evt(wake_evt), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pd(pad_pd));
    cio_pad_model u_pads (.pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pd(pad_pd), .ext_en(ext_en), .ext_drv(ext_drv),
        .pad_in(pad_in));

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Sends one configuration command and notes a refusal if expected.
    task automatic cmd(input logic [3:0] p, input logic [1:0] m,
                       input logic val, input bit bad);
        @(posedge clk_sys);
        #2 cmd_valid = 1'b1;
        cmd_pin = p;
        cmd_mode = m;
        cmd_value = val;
        err_exp += bad;
        @(posedge clk_sys);
        #2 cmd_valid = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // Issues one read and queues the level it must answer.
    task automatic rd(input logic [3:0] p, input logic e);
        rd_q.push_back(e);
        @(posedge clk_sys);
        #2 rd_req = 1'b1;
        rd_pin = p;
        @(posedge clk_sys);
        #2 rd_req = 1'b0;
    endtask

    // Counts indicator high cycles over two blink periods.
    task automatic cnt_high();
        n = 0;
        repeat (24) begin
            @(posedge clk_sys);
            #1 n += int'(pad_out[0]);
        end
    endtask

    // Moves the device status and waits for the indicator to follow.
    task automatic dev(input cio_pkg::cio_dev_e s);
        @(posedge clk_sys);
        #2 dev_state = s;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // Takes the oldest queued read and compares the answer with it.
    always @(posedge clk_sys) begin
        if (rd_done === 1'b1)
            chk("rd_data", rd_q.size() ? rd_q.pop_front() : 1'bx,
                rd_data);
        if (cmd_err === 1'b1)
            err_seen++;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        #(40 * 6000);
        err_total++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge clk_sys);
        #2 rst = 1'b0;
        chk("pad_oe", 10'h000, pad_oe);
        chk("pad_pd", 10'h3FF, pad_pd);
        ext_drv = 10'($random(seed));
        repeat (3) @(posedge clk_sys);
        for (int p = 1; p <= 10; p++)
            rd(4'(p), ext_drv[p-1]);
        rd(4'h0, 1'b0);
        v = 1'($random(seed));
        cmd(4'h3, cio_pkg::MODE_OUT, v, 0);
        cmd(4'h4, cio_pkg::MODE_OUT, ~v, 0);
        chk("pad_oe", 10'h00C, pad_oe);
        chk("pad_pd", 10'h3F3, pad_pd);
        chk("pad_out", {6'h00, ~v, v, 2'h0}, pad_out & 10'h00C);
        rd(4'h3, v);
        rd(4'h4, ~v);
        cmd(4'h3, cio_pkg::MODE_IN, 1'b1, 0);
        chk("pad_oe", 10'h008, pad_oe);
        rd(4'h3, ext_drv[2]);
        rd(4'h4, ~v);
        for (int k = 0; k < 4; k++)
            cmd(k[1] ? 4'(11 * k[0]) : 4'h2, k[1] ? 2'h1 : 2'(2 + k), 0, 1);
        chk("cmd_err", err_exp, err_seen);
        chk("pad_oe", 10'h008, pad_oe);
        cmd(4'h1, cio_pkg::MODE_ALT, 1'b1, 0);
        chk("led off", 1'b0, pad_out[0]);
        chk("led oe", 1'b1, pad_oe[0]);
        dev(cio_pkg::CIO_DEV_IDLE);
        chk("led first", 1'b1, pad_out[0]);
        cnt_high();
        chk("idle highs", 8, n);
        dev(cio_pkg::CIO_DEV_CONNECTING);
        cnt_high();
        chk("conn highs", 8, n);
        dev(cio_pkg::CIO_DEV_IDLE_PSM);
        v = pad_out[0];
        cnt_high();
        chk("psm still", 32'(v) * 24, n);
        @(posedge clk_sys);
        #2 wake_evt = 1'b1;
        @(posedge clk_sys);
        #2 wake_evt = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("psm wake", 32'(!v), pad_out[0]);
        rd(4'h1, ~v);
        dev(cio_pkg::CIO_DEV_NOT_REG);
        chk("led notreg", 1'b1, pad_out[0]);
        dev(cio_pkg::CIO_DEV_OFF);
        chk("led off", 1'b0, pad_out[0]);
        repeat (3) @(posedge clk_sys);
        chk("rd left", 0, rd_q.size());
        print_verdict();
    end
endmodule
`default_nettype wire
